// File: design/gle_expander.sv
// gle_expander: 16-pin gpio / led expander behind a serial two-wire slave.
// assumes scl, sda, pins, straps and reset pin are asynchronous to ref_clk;
// ref_clk must be well above 20x the serial clock rate.
//
// Function
// - each pin selects led or gpio mode; gpio direction per pin
// - after reset all pins are gpio outputs, levels from address straps
// - default levels: sel1 sets pins 7..4, sel0 sets pins 3..0, both banks
// - bank1 always push-pull; bank0 open-drain unless switched to push-pull
// - direction bit 1 is input, 0 output; both direction registers reset 0
// - reading an input-state register returns present pin levels of that bank
// - only gpio inputs with interrupt enabled are watched for changes
// - pending interrupt pulls the open-drain interrupt line low, else released
// - any edge raises interrupt after the new level holds 8 us
// - bank interrupt clears only by reading that bank's input-state register
// - led mode sources dim level n of 255 full scale, zero is off
// - two-bit range field picks one of four full-scale grades
// - range 00 full, 01 three quarters, 10 half, 11 quarter
// - global control bit 4 selects bank0 push-pull, resets to 0
// - interrupt mask bit 0 enables, 1 disables; masks reset 0
// - slave address is 10110 then sel1, sel0, then read/write bit
// - general call address is never acknowledged
// - matched address and every received byte are acknowledged
// - write: pointer byte then data, pointer increments per byte
// - read from pointer after repeated start, successive registers follow
// - on master nack the slave releases data so master can stop
// - power-on, pin and software resets return registers to defaults
// - reset pin lows under 10 us ignored, over 20 us reset
// - short high spikes inside a valid reset low are ignored
// - after reset interrupt released and pins back to default outputs
// - writing 00 to register 7F resets like the reset pin; the serial slave and its pointer are not reset
`timescale 1ns/1ps
module gle_expander #(
   parameter int DEGLITCH_CYC = gle_pkg::DEGLITCH_CYC,
   parameter logic [7:0] ID_VALUE = 8'h5A // arbitrary value
)(
   // clock and resets
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hw_reset_pin_n,
   // address straps
   input wire logic addr_sel_pin0,
   input wire logic addr_sel_pin1,
   // serial bus
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // interrupt, open drain
   output logic irq_out_n,
   output logic irq_out_n_oe,
   // io pins, [7:0] bank0 and [15:8] bank1
   input wire logic [15:0] pin_in,
   output gle_pkg::gle_pin_drv_t pin_drive,
   // led current sources
   output logic [15:0][7:0] led_dim_level,
   output logic [1:0] current_range_sel
);
   localparam int DGW = $clog2(DEGLITCH_CYC + 1);
   localparam int RLW = $clog2(gle_pkg::RST_LOW_CYC + 1);
   localparam int RHW = $clog2(gle_pkg::RST_SPIKE_CYC + 1);
   localparam int INW = $clog2(gle_pkg::INIT_CYC + 1);

   generate
      if (DEGLITCH_CYC < 2 || DEGLITCH_CYC > 4095) begin : g_bad
         $error("DEGLITCH_CYC out of range");
      end
   endgenerate

   // synchronisers
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   logic rpin_s1, rpin_s2;
   logic [1:0] ad_s1, ad_s2;
   logic [15:0] pin_s1, pin_s2;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         rpin_s1 <= 1'b1;
         rpin_s2 <= 1'b1;
         ad_s1 <= 2'h0;
         ad_s2 <= 2'h0;
         pin_s1 <= 16'h0000;
         pin_s2 <= 16'h0000;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         rpin_s1 <= hw_reset_pin_n;
         rpin_s2 <= rpin_s1;
         ad_s1 <= {addr_sel_pin1, addr_sel_pin0};
         ad_s2 <= ad_s1;
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // reset pin filter: low run must pass the accept point, high runs shorter
   // than the spike width neither abort a low run nor end a held reset
   logic [RLW-1:0] rlow_cnt;
   logic [RHW-1:0] rhigh_cnt;
   logic pin_rst_reg, soft_rst_reg, clr;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rlow_cnt <= '0;
         rhigh_cnt <= '0;
         pin_rst_reg <= 1'b0;
      end else if (!rpin_s2) begin
         rhigh_cnt <= '0;
         if (rlow_cnt != RLW'(gle_pkg::RST_LOW_CYC)) begin
            rlow_cnt <= rlow_cnt + 1'b1;
         end else begin
            pin_rst_reg <= 1'b1;
         end
      end else if (rhigh_cnt != RHW'(gle_pkg::RST_SPIKE_CYC)) begin
         rhigh_cnt <= rhigh_cnt + 1'b1;
      end else begin
         rlow_cnt <= '0;
         pin_rst_reg <= 1'b0;
      end
   end

   assign clr = pin_rst_reg | soft_rst_reg;

   // serial slave
   gle_pkg::gle_i2c_st_t st;
   gle_pkg::gle_reg_wr_t wr_reg;
   logic [2:0] bitc;
   logic [7:0] sh, ptr, rd_data;
   logic full, rw, is_ptr, mack;
   logic [1:0] rd_clr;
   logic start, stop, rise, fall, load;

   assign start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign rise = scl_s2 & ~scl_d;
   assign fall = ~scl_s2 & scl_d;
   assign load = fall & (((st == gle_pkg::GLE_ACK) & rw) | ((st == gle_pkg::GLE_MACK) & mack));

   // soft reset leaves the slave alone so the ack of that write completes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= gle_pkg::GLE_IDLE;
         wr_reg <= '0;
         bitc <= 3'h0;
         sh <= 8'h00;
         ptr <= 8'h00;
         full <= 1'b0;
         rw <= 1'b0;
         is_ptr <= 1'b0;
         mack <= 1'b0;
         rd_clr <= 2'h0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end else if (pin_rst_reg) begin
         st <= gle_pkg::GLE_IDLE;
         wr_reg <= '0;
         ptr <= 8'h00;
         rd_clr <= 2'h0;
         sda_oe <= 1'b0;
      end else begin
         wr_reg.wr <= 1'b0;
         rd_clr <= 2'h0;
         if (start) begin
            st <= gle_pkg::GLE_ADDR;
            bitc <= 3'h0;
            full <= 1'b0;
            is_ptr <= 1'b1;
            sda_oe <= 1'b0;
         end else if (stop) begin
            st <= gle_pkg::GLE_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (st)
               gle_pkg::GLE_ADDR, gle_pkg::GLE_RX: begin
                  if (rise) begin
                     sh <= {sh[6:0], sda_s2};
                     bitc <= bitc + 3'h1;
                     full <= (bitc == 3'h7);
                  end else if (fall && full) begin
                     full <= 1'b0;
                     if (st == gle_pkg::GLE_RX) begin
                        st <= gle_pkg::GLE_ACK;
                        sda_oe <= 1'b1;
                        rw <= 1'b0;
                        if (is_ptr) begin
                           ptr <= sh;
                           is_ptr <= 1'b0;
                        end else begin
                           wr_reg <= '{wr: 1'b1, addr: ptr, data: sh};
                           ptr <= ptr + 8'h01;
                        end
                     end else if (sh[7:1] == {gle_pkg::SLAVE_ADDR_HI, ad_s2}) begin
                        st <= gle_pkg::GLE_ACK;
                        sda_oe <= 1'b1;
                        rw <= sh[0];
                     end else begin
                        st <= gle_pkg::GLE_IDLE;
                     end
                  end
               end
               gle_pkg::GLE_ACK, gle_pkg::GLE_MACK: begin
                  if (rise && st == gle_pkg::GLE_MACK) begin
                     mack <= ~sda_s2;
                  end else if (load) begin
                     st <= gle_pkg::GLE_TX;
                     sh <= rd_data;
                     sda_oe <= ~rd_data[7];
                     bitc <= 3'h0;
                     ptr <= ptr + 8'h01;
                     rd_clr <= {ptr == gle_pkg::REG_IN1, ptr == gle_pkg::REG_IN0};
                  end else if (fall && st == gle_pkg::GLE_ACK) begin
                     st <= gle_pkg::GLE_RX;
                     sda_oe <= 1'b0;
                     bitc <= 3'h0;
                     full <= 1'b0;
                  end else if (fall) begin
                     st <= gle_pkg::GLE_IDLE;
                  end
               end
               gle_pkg::GLE_TX: begin
                  if (fall) begin
                     if (bitc == 3'h7) begin
                        st <= gle_pkg::GLE_MACK;
                        sda_oe <= 1'b0;
                     end else begin
                        sh <= {sh[6:0], 1'b0};
                        sda_oe <= ~sh[6];
                        bitc <= bitc + 3'h1;
                     end
                  end
               end
               gle_pkg::GLE_IDLE: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  st <= gle_pkg::GLE_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // register file
   logic [7:0] out0_reg, out1_reg, dir0_reg, dir1_reg, mask0_reg, mask1_reg;
   logic [7:0] mode0_reg, mode1_reg;
   logic [1:0] range_reg;
   logic drive_pp_reg;
   logic [7:0] dim_reg [16];
   logic [INW-1:0] init_cnt;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= wr_reg.wr && wr_reg.addr == gle_pkg::REG_SOFT_RST
                         && wr_reg.data == gle_pkg::SOFT_RST_KEY;
      end
   end

   // straps are caught a few cycles after any reset, once synchronised
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_cnt <= INW'(gle_pkg::INIT_CYC);
      end else if (clr) begin
         init_cnt <= INW'(gle_pkg::INIT_CYC);
      end else if (init_cnt != '0) begin
         init_cnt <= init_cnt - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out0_reg <= 8'h00;
         out1_reg <= 8'h00;
         dir0_reg <= gle_pkg::DIR_RST;
         dir1_reg <= gle_pkg::DIR_RST;
         mask0_reg <= gle_pkg::MASK_RST;
         mask1_reg <= gle_pkg::MASK_RST;
         mode0_reg <= gle_pkg::MODE_RST;
         mode1_reg <= gle_pkg::MODE_RST;
         range_reg <= gle_pkg::RANGE_RST;
         drive_pp_reg <= 1'b0;
      end else if (clr) begin
         out0_reg <= 8'h00;
         out1_reg <= 8'h00;
         dir0_reg <= gle_pkg::DIR_RST;
         dir1_reg <= gle_pkg::DIR_RST;
         mask0_reg <= gle_pkg::MASK_RST;
         mask1_reg <= gle_pkg::MASK_RST;
         mode0_reg <= gle_pkg::MODE_RST;
         mode1_reg <= gle_pkg::MODE_RST;
         range_reg <= gle_pkg::RANGE_RST;
         drive_pp_reg <= 1'b0;
      end else if (init_cnt != '0) begin
         out0_reg <= (ad_s2[1] ? gle_pkg::DFLT_SEL1 : 8'h00)
                     | (ad_s2[0] ? gle_pkg::DFLT_SEL0 : 8'h00);
         out1_reg <= (ad_s2[1] ? gle_pkg::DFLT_SEL1 : 8'h00)
                     | (ad_s2[0] ? gle_pkg::DFLT_SEL0 : 8'h00);
      end else if (wr_reg.wr) begin
         case (wr_reg.addr)
            gle_pkg::REG_OUT0: out0_reg <= wr_reg.data;
            gle_pkg::REG_OUT1: out1_reg <= wr_reg.data;
            gle_pkg::REG_DIR0: dir0_reg <= wr_reg.data;
            gle_pkg::REG_DIR1: dir1_reg <= wr_reg.data;
            gle_pkg::REG_MASK0: mask0_reg <= wr_reg.data;
            gle_pkg::REG_MASK1: mask1_reg <= wr_reg.data;
            gle_pkg::REG_MODE0: mode0_reg <= wr_reg.data;
            gle_pkg::REG_MODE1: mode1_reg <= wr_reg.data;
            gle_pkg::REG_GCTL: begin
               drive_pp_reg <= wr_reg.data[gle_pkg::GCTL_DRIVE_BIT];
               range_reg <= wr_reg.data[gle_pkg::GCTL_RANGE_LSB +: 2];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            dim_reg[i] <= gle_pkg::DIM_RST;
         end
      end else if (clr) begin
         for (int i = 0; i < 16; i++) begin
            dim_reg[i] <= gle_pkg::DIM_RST;
         end
      end else if (wr_reg.wr && wr_reg.addr[7:4] == gle_pkg::REG_DIM_PAGE) begin
         dim_reg[wr_reg.addr[3:0]] <= wr_reg.data;
      end
   end

   always_comb begin
      case (ptr)
         gle_pkg::REG_IN0: rd_data = pin_s2[7:0];
         gle_pkg::REG_IN1: rd_data = pin_s2[15:8];
         gle_pkg::REG_OUT0: rd_data = out0_reg;
         gle_pkg::REG_OUT1: rd_data = out1_reg;
         gle_pkg::REG_DIR0: rd_data = dir0_reg;
         gle_pkg::REG_DIR1: rd_data = dir1_reg;
         gle_pkg::REG_MASK0: rd_data = mask0_reg;
         gle_pkg::REG_MASK1: rd_data = mask1_reg;
         gle_pkg::REG_ID: rd_data = ID_VALUE;
         gle_pkg::REG_GCTL: rd_data = {3'h0, drive_pp_reg, 2'h0, range_reg};
         gle_pkg::REG_MODE0: rd_data = mode0_reg;
         gle_pkg::REG_MODE1: rd_data = mode1_reg;
         default: rd_data = 8'h00;
      endcase
   end

   // input deglitch and interrupt
   logic [15:0] stable_reg, hit_reg, mon;
   logic [1:0] pend_reg;
   assign mon = {dir1_reg & mode1_reg & ~mask1_reg, dir0_reg & mode0_reg & ~mask0_reg};

   for (genvar g = 0; g < 16; g++) begin : g_dg
      logic [DGW-1:0] dg_cnt;
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            dg_cnt <= '0;
            stable_reg[g] <= 1'b0;
            hit_reg[g] <= 1'b0;
         end else begin
            hit_reg[g] <= 1'b0;
            if (pin_s2[g] == stable_reg[g]) begin
               dg_cnt <= '0;
            end else if (dg_cnt == DGW'(DEGLITCH_CYC - 1)) begin
               dg_cnt <= '0;
               stable_reg[g] <= pin_s2[g];
               hit_reg[g] <= 1'b1;
            end else begin
               dg_cnt <= dg_cnt + 1'b1;
            end
         end
      end
   end

   // a change in the cycle of the clearing read still sets the flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_reg <= 2'h0;
      end else if (clr) begin
         pend_reg <= 2'h0;
      end else begin
         pend_reg[0] <= (|(hit_reg[7:0] & mon[7:0])) | (pend_reg[0] & ~rd_clr[0]);
         pend_reg[1] <= (|(hit_reg[15:8] & mon[15:8])) | (pend_reg[1] & ~rd_clr[1]);
      end
   end

   // pin and output drivers
   logic [7:0] gpo0, gpo1;
   assign gpo0 = ~dir0_reg & mode0_reg;
   assign gpo1 = ~dir1_reg & mode1_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_drive <= '0;
         irq_out_n <= 1'b0;
         irq_out_n_oe <= 1'b0;
         led_dim_level <= '0;
         current_range_sel <= gle_pkg::RANGE_RST;
      end else begin
         irq_out_n <= 1'b0;
         irq_out_n_oe <= |pend_reg;
         pin_drive.out[15:8] <= out1_reg;
         pin_drive.oe[15:8] <= gpo1;
         pin_drive.out[7:0] <= drive_pp_reg ? out0_reg : 8'h00;
         pin_drive.oe[7:0] <= drive_pp_reg ? gpo0 : (gpo0 & ~out0_reg);
         current_range_sel <= range_reg;
         for (int j = 0; j < 8; j++) begin
            led_dim_level[j] <= mode0_reg[j] ? 8'h00 : dim_reg[4 + j];
            led_dim_level[8 + j] <= mode1_reg[j] ? 8'h00 : dim_reg[j < 4 ? j : 8 + j];
         end
      end
   end

   // checks
   sequence s_addr_byte;
      (st == gle_pkg::GLE_ADDR) && fall && full;
   endsequence
   sequence s_match;
      sh[7:1] == {gle_pkg::SLAVE_ADDR_HI, ad_s2};
   endsequence

   addr_ack_a: assert property (@(posedge ref_clk) disable iff (rst || pin_rst_reg)
      s_addr_byte ##0 s_match ##0 (!start && !stop) |=> sda_oe && st == gle_pkg::GLE_ACK)
      else $error("matched address not acknowledged");
   gen_call_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_addr_byte ##0 (sh[7:1] == 7'h00) |=> !sda_oe)
      else $error("general call acknowledged");
   mack_release_a: assert property (@(posedge ref_clk) disable iff (rst)
      st == gle_pkg::GLE_MACK |-> !sda_oe)
      else $error("data held during master acknowledge");
   irq_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
      (|pend_reg) |=> irq_out_n_oe && !irq_out_n)
      else $error("pending interrupt not driven");
   irq_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      pend_reg[0] && !rd_clr[0] && !clr |=> pend_reg[0])
      else $error("bank0 interrupt lost without read");
   deglitch_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(pend_reg[1]) |-> $past(|(hit_reg[15:8] & mon[15:8])))
      else $error("bank1 interrupt without settled change");
   od_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
      !drive_pp_reg ##1 !drive_pp_reg |-> pin_drive.out[7:0] == 8'h00)
      else $error("bank0 open drain drove high");
   soft_rst_a: assert property (@(posedge ref_clk) disable iff (rst)
      wr_reg.wr && wr_reg.addr == gle_pkg::REG_SOFT_RST && wr_reg.data == 8'h00
      |=> soft_rst_reg ##1 dir0_reg == 8'h00 && pend_reg == 2'h0)
      else $error("soft reset had no effect");
   pin_rst_a: assert property (@(posedge ref_clk) disable iff (rst)
      !rpin_s2 && rlow_cnt < RLW'(100) |=> !pin_rst_reg || $past(pin_rst_reg))
      else $error("short reset pulse accepted");
   dir_in_a: assert property (@(posedge ref_clk) disable iff (rst)
      dir1_reg[0] |=> !pin_drive.oe[8])
      else $error("input pin still driven");
endmodule

// File: shared/gle_pkg.sv
// gle_pkg: constants, states and carriers of the gpio/led expander.
// assumes a 10 MHz reference clock; all times become cycle counts here.
package gle_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int DEGLITCH_NS = 8000;
   localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_REJECT_NS = 10000;
   localparam int RST_ACCEPT_NS = 20000;
   // accept point sits between the reject and accept widths
   localparam int RST_LOW_CYC = ((RST_REJECT_NS + RST_ACCEPT_NS) / 2) / CLK_PERIOD_NS;
   localparam int RST_SPIKE_NS = 500;
   localparam int RST_SPIKE_CYC = RST_SPIKE_NS / CLK_PERIOD_NS;
   localparam int INIT_CYC = 3;
   // slave address upper five bits
   localparam logic [4:0] SLAVE_ADDR_HI = 5'h16;
   // register offsets
   localparam logic [7:0] REG_IN0 = 8'h00;
   localparam logic [7:0] REG_IN1 = 8'h01;
   localparam logic [7:0] REG_OUT0 = 8'h02;
   localparam logic [7:0] REG_OUT1 = 8'h03;
   localparam logic [7:0] REG_DIR0 = 8'h04;
   localparam logic [7:0] REG_DIR1 = 8'h05;
   localparam logic [7:0] REG_MASK0 = 8'h06;
   localparam logic [7:0] REG_MASK1 = 8'h07;
   localparam logic [7:0] REG_ID = 8'h10;
   localparam logic [7:0] REG_GCTL = 8'h11;
   localparam logic [7:0] REG_MODE0 = 8'h12;
   localparam logic [7:0] REG_MODE1 = 8'h13;
   localparam logic [3:0] REG_DIM_PAGE = 4'h2;
   localparam logic [7:0] REG_SOFT_RST = 8'h7F;
   localparam logic [7:0] SOFT_RST_KEY = 8'h00;
   // global control fields
   localparam int GCTL_DRIVE_BIT = 4;
   localparam int GCTL_RANGE_LSB = 0;
   // reset values
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'hFF;
   localparam logic [7:0] DIM_RST = 8'h00;
   localparam logic [1:0] RANGE_RST = 2'h0;
   localparam logic [7:0] DFLT_SEL0 = 8'h0F;
   localparam logic [7:0] DFLT_SEL1 = 8'hF0;
   // serial slave states, gray along the write path
   typedef enum logic [2:0] {
      GLE_IDLE = 3'b000,
      GLE_ADDR = 3'b001,
      GLE_ACK = 3'b011,
      GLE_RX = 3'b010,
      GLE_TX = 3'b110,
      GLE_MACK = 3'b111
   } gle_i2c_st_t;
   // pin drive: [7:0] bank0, [15:8] bank1
   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } gle_pin_drv_t;
   // one register write from the serial slave
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } gle_reg_wr_t;
endpackage

// File: sim/gle_i2c_master.sv
// gle_i2c_master: serial bus master model, drives scl and pulls sda low.
// assumes a pull-up on sda; a released wire reads high.
`timescale 1ns/1ps
module gle_i2c_master (
   // clock
   input wire logic ref_clk,
   // bus
   input wire logic sda,
   output logic scl = 1'b1,
   output logic sda_low = 1'b0
);
   // lines change only on ref_clk edges, 8 cycles a bit
   task automatic step(input logic c, input logic l, input int n);
      scl <= c;
      sda_low <= l;
      repeat (n) @(posedge ref_clk);
   endtask
   // also serves as repeated start
   task automatic start();
      step(1'b0, 1'b0, 4);
      step(1'b1, 1'b0, 4);
      step(1'b1, 1'b1, 4);
      step(1'b0, 1'b1, 4);
   endtask
   task automatic stop();
      step(1'b0, 1'b1, 4);
      step(1'b1, 1'b1, 4);
      step(1'b1, 1'b0, 4);
   endtask
   // data moves 3 cycles after scl falls, clear of the synchroniser lag
   task automatic bitio(input logic b, output logic r);
      step(1'b0, ~b, 1);
      step(1'b1, ~b, 2);
      r = sda;
      step(1'b1, ~b, 2);
      step(1'b0, ~b, 3);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitio(d[i], r);
      bitio(1'b1, r);
      ack = ~r;
   endtask
   // nack on the last byte hands the line back for stop
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitio(1'b1, d[i]);
      bitio(last, r);
   endtask
endmodule

// File: sim/tb.sv
// tb: register-level tests of the expander through the bus master model.
// assumes straps start at sel1=1 sel0=0 and pull-ups on every pin and on sda.
`timescale 1ns/1ps
module tb;
   localparam logic [6:0] ADR = 7'h5A;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hw_reset_pin_n = 1'b1;
   logic sel0 = 1'b0;
   logic sel1 = 1'b1;
   logic [15:0] ext = 16'hFFFF;
   logic scl, sda_low, sda_out, sda_oe, irq_n, irq_oe;
   wire sda = ~(sda_low | sda_oe);
   logic [15:0] pin_in;
   gle_pkg::gle_pin_drv_t drv;
   logic [15:0][7:0] dim;
   logic [1:0] cur_rng;
   int fails = 0;
   int checks_done = 0;
   assign pin_in = (drv.out & drv.oe) | (ext & ~drv.oe);
   always #50 ref_clk = ~ref_clk;
   gle_expander #(.DEGLITCH_CYC(4), .ID_VALUE(8'hC3)) dut (.ref_clk(ref_clk), .rst(rst),
      .hw_reset_pin_n(hw_reset_pin_n), .addr_sel_pin0(sel0), .addr_sel_pin1(sel1),
      .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq_out_n(irq_n),
      .irq_out_n_oe(irq_oe), .pin_in(pin_in), .pin_drive(drv), .led_dim_level(dim),
      .current_range_sel(cur_rng));
   gle_i2c_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
      logic a;
      m.start();
      m.wbyte({ADR, 1'b0}, a);
      chk(a, 1'b1);
      m.wbyte(p, a);
      chk(a, 1'b1);
      for (int i = n - 1; i >= 0; i--) begin
         m.wbyte(d[i*8+:8], a);
         chk(a, 1'b1);
      end
      m.stop();
      cyc(4);
   endtask
   task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
      logic a;
      v = 16'h0000;
      m.start();
      m.wbyte({ADR, 1'b0}, a);
      m.wbyte(p, a);
      m.start();
      m.wbyte({ADR, 1'b1}, a);
      chk(a, 1'b1);
      for (int i = n - 1; i >= 0; i--) m.rbyte(i == 0, v[i*8+:8]);
      chk(sda_oe, 1'b0);
      m.stop();
      cyc(4);
   endtask
   task automatic probe(input logic [7:0] b, input logic e);
      logic a;
      m.start();
      m.wbyte(b, a);
      m.stop();
      chk(a, e);
   endtask
   initial begin
      logic [15:0] v;
      cyc(6);
      rst <= 1'b0;
      cyc(10);
      rd(8'h02, 2, v);
      chk(v, 16'hF0F0);
      chk(drv.out[15:8], 8'hF0);
      chk(drv.oe, 16'hFF0F);
      rd(8'h04, 2, v);
      chk(v, 16'h0000);
      rd(8'h06, 2, v);
      chk(v, 16'h0000);
      for (int k = 3; k >= 0; k--) begin
         wr(8'h11, {8'h00, 6'h04, k[1:0]}, 1);
         chk(cur_rng, k[1:0]);
      end
      chk(drv.oe[7:0], 8'hFF);
      wr(8'h02, 16'hA53C, 2);
      chk(drv.out, 16'h3CA5);
      rd(8'h02, 2, v);
      chk(v, 16'hA53C);
      ext[7:0] <= 8'h5A;
      wr(8'h04, 16'h00FF, 1);
      chk(drv.oe[7:0], 8'h00);
      rd(8'h00, 1, v);
      chk(v[7:0], 8'h5A);
      chk(irq_oe, 1'b0);
      ext[1] <= 1'b0;
      cyc(2);
      ext[1] <= 1'b1;
      cyc(15);
      chk(irq_oe, 1'b0);
      ext[0] <= 1'b1;
      cyc(15);
      chk(irq_oe, 1'b1);
      rd(8'h01, 1, v);
      chk(irq_oe, 1'b1);
      rd(8'h00, 1, v);
      chk(irq_oe, 1'b0);
      wr(8'h06, 16'h0001, 1);
      ext[0] <= 1'b0;
      wr(8'h03, 16'h0055, 1);
      cyc(15);
      chk(irq_oe, 1'b0);
      wr(8'h12, 16'h00FE, 1);
      wr(8'h24, 16'h8040, 2);
      chk(dim[0], 8'h80);
      chk(dim[1], 8'h00);
      wr(8'h13, 16'h007F, 1);
      wr(8'h2F, 16'h0033, 1);
      chk(dim[15], 8'h33);
      chk(drv.oe[15], 1'b0);
      wr(8'h0F, 16'h0077, 1);
      rd(8'h0F, 2, v);
      chk(v, 16'h00C3);
      probe(8'h00, 1'b0);
      probe(8'hB6, 1'b0);
      probe(8'hB4, 1'b1);
      wr(8'h7F, 16'h0000, 1);
      rd(8'h02, 2, v);
      chk(v, 16'hF0F0);
      chk(dim[0], 8'h00);
      wr(8'h05, 16'h00FF, 1);
      hw_reset_pin_n <= 1'b0;
      cyc(50);
      hw_reset_pin_n <= 1'b1;
      cyc(20);
      rd(8'h05, 1, v);
      chk(v[7:0], 8'hFF);
      hw_reset_pin_n <= 1'b0;
      cyc(120);
      hw_reset_pin_n <= 1'b1;
      cyc(2);
      hw_reset_pin_n <= 1'b0;
      cyc(100);
      hw_reset_pin_n <= 1'b1;
      cyc(20);
      rd(8'h05, 1, v);
      chk(v[7:0], 8'h00);
      chk(drv.oe, 16'hFF0F);
      chk(irq_oe, 1'b0);
      // second power-on reset with the other strap pair
      sel0 <= 1'b1;
      sel1 <= 1'b0;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(10);
      chk(drv.out, 16'h0F00);
      chk(drv.oe, 16'hFFF0);
      probe(8'hB2, 1'b1);
      probe(8'hB4, 1'b0);
      chk(sda_out, 1'b0);
      chk(irq_n, 1'b0);
      give_verdict();
   end
   // run needs about 9000 cycles
   initial begin
      cyc(40000);
      fails++;
      give_verdict();
   end
endmodule
